// ===== rtl/rss_pkg.sv
// shared constants and types for the reset strap sampler
package rss_pkg;

  // clock and strap sampling time
  localparam int CLK_PERIOD_NS = 40;
  localparam int STRAP_SAMPLE_DELAY_NS = 1500;
  // the delay is nominal, so a partial cycle rounds up to a whole one
  localparam int SAMPLE_CYCLES =
    (STRAP_SAMPLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W = 6;

  // pin positions inside the packed pin vector
  localparam int PIN_COUNT = 8;
  localparam int STRAP_HOST_SEL = 0;
  localparam int STRAP_SPI_MODE = 1;
  localparam int STRAP_INTEGRITY = 2;
  localparam int STRAP_BOOT_HOLD = 3;
  localparam int SPARE_LSB = 4;
  localparam int SPARE_MSB = 7;

  // strap level encodings
  localparam logic HOST_PORT_SPI = 1'b0;
  localparam logic HOST_PORT_I2C = 1'b1;
  localparam logic SPI_MODE_0_OR_3 = 1'b0;
  localparam logic SPI_MODE_1_OR_2 = 1'b1;
  localparam logic INTEGRITY_CRC8 = 1'b0;
  localparam logic INTEGRITY_CHECKSUM8 = 1'b1;
  localparam logic BOOT_LOAD_MAIN = 1'b0;
  localparam logic BOOT_STAY = 1'b1;

  // reset values
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 8'h00;
  localparam logic [SAMPLE_CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [SAMPLE_CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [15:0] EDGE_ZERO = 16'h0000;
  localparam logic [15:0] EDGE_ONE = 16'h0001;
  localparam logic [15:0] EDGE_MAX = 16'hffff;

  // sequencer states
  typedef enum logic [1:0] {
    st_wait = 2'b01,
    st_capture = 2'b10,
    st_run = 2'b11
  } rss_state_type;

endpackage

// ===== rtl/rss_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module rss_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage; nothing else may look at it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ===== rtl/rss_strap_sampler.sv
// reset strap sampler: latches board straps after power-on reset release
`timescale 1ns/1ps
// Notes on behaviour
// - sampled host port select low picks SPI, high picks I2C for commands
// - the host port not chosen for commands becomes the diagnostic port
// - SPI mode strap low means mode 0 or 3, high means 1 or 2
// - SPI mode applies to host SPI whatever role that port plays
// - integrity strap low means 8-bit CRC, high 8-bit checksum; host agrees
// - integrity strap covers the command port only; diagnostic uses flash
// - boot hold high stays in boot, low loads the main application
// - all strap pins undriven while power-on reset is low
// - straps sampled about 1.5 us after reset release; host holds them
// - a strap pin may drive debug data only after it was sampled
// - undriven strap reads low through weak pull-down, the zero option
// - reset active low; configuration starts on its rising edge
module rss_strap_sampler #(
  parameter int SAMPLE_CYCLES = rss_pkg::SAMPLE_CYCLES,
  parameter int CNT_W = rss_pkg::SAMPLE_CNT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic host_port_select_strap_in,
  output logic host_port_select_strap_out,
  output logic host_port_select_strap_oe,
  input wire logic spi_mode_strap_in,
  output logic spi_mode_strap_out,
  output logic spi_mode_strap_oe,
  input wire logic integrity_method_strap_in,
  output logic integrity_method_strap_out,
  output logic integrity_method_strap_oe,
  input wire logic boot_hold_strap_in,
  output logic boot_hold_strap_out,
  output logic boot_hold_strap_oe,
  input wire logic spare_test_pin_a_in,
  output logic spare_test_pin_a_out,
  output logic spare_test_pin_a_oe,
  input wire logic spare_test_pin_b_in,
  output logic spare_test_pin_b_out,
  output logic spare_test_pin_b_oe,
  input wire logic spare_test_pin_c_in,
  output logic spare_test_pin_c_out,
  output logic spare_test_pin_c_oe,
  input wire logic spare_test_pin_d_in,
  output logic spare_test_pin_d_out,
  output logic spare_test_pin_d_oe,
  input wire logic flash_diag_checksum,
  input wire logic [rss_pkg::PIN_COUNT-1:0] debug_out_enable,
  input wire logic [rss_pkg::PIN_COUNT-1:0] debug_out_value,
  output logic strap_valid,
  output logic cmd_port_is_i2c,
  output logic diag_port_is_i2c,
  output logic host_spi_mode_1_or_2,
  output logic cmd_integrity_checksum,
  output logic diag_integrity_checksum,
  output logic stay_in_boot,
  output logic load_main_app,
  output logic spare_pin_fault
);

  logic [rss_pkg::PIN_COUNT-1:0] pin_raw;
  logic [rss_pkg::PIN_COUNT-1:0] pin_s;
  logic [rss_pkg::PIN_COUNT-1:0] pin_out;
  logic [rss_pkg::PIN_COUNT-1:0] next_pin_out;
  logic [rss_pkg::PIN_COUNT-1:0] pin_oe;
  logic [rss_pkg::PIN_COUNT-1:0] next_pin_oe;
  rss_pkg::rss_state_type state;
  rss_pkg::rss_state_type next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_valid;
  logic next_cmd_i2c;
  logic next_diag_i2c;
  logic next_spi_mode;
  logic next_cmd_checksum;
  logic next_diag_checksum;
  logic next_stay_boot;
  logic next_load_main;
  logic next_spare_fault;
  logic [15:0] edges;
  logic [15:0] next_edges;

  // gather the pins into one vector so they can share a synchroniser
  assign pin_raw[rss_pkg::STRAP_HOST_SEL] = host_port_select_strap_in;
  assign pin_raw[rss_pkg::STRAP_SPI_MODE] = spi_mode_strap_in;
  assign pin_raw[rss_pkg::STRAP_INTEGRITY] = integrity_method_strap_in;
  assign pin_raw[rss_pkg::STRAP_BOOT_HOLD] = boot_hold_strap_in;
  assign pin_raw[rss_pkg::SPARE_LSB] = spare_test_pin_a_in;
  assign pin_raw[rss_pkg::SPARE_LSB+1] = spare_test_pin_b_in;
  assign pin_raw[rss_pkg::SPARE_LSB+2] = spare_test_pin_c_in;
  assign pin_raw[rss_pkg::SPARE_MSB] = spare_test_pin_d_in;

  // board levels are asynchronous to clk
  rss_sync #(
    .WIDTH(rss_pkg::PIN_COUNT)
  ) pin_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d(pin_raw),
    .q(pin_s)
  );

  // pin drivers, taken straight from the pin flops
  assign host_port_select_strap_out = pin_out[rss_pkg::STRAP_HOST_SEL];
  assign spi_mode_strap_out = pin_out[rss_pkg::STRAP_SPI_MODE];
  assign integrity_method_strap_out = pin_out[rss_pkg::STRAP_INTEGRITY];
  assign boot_hold_strap_out = pin_out[rss_pkg::STRAP_BOOT_HOLD];
  assign spare_test_pin_a_out = pin_out[rss_pkg::SPARE_LSB];
  assign spare_test_pin_b_out = pin_out[rss_pkg::SPARE_LSB+1];
  assign spare_test_pin_c_out = pin_out[rss_pkg::SPARE_LSB+2];
  assign spare_test_pin_d_out = pin_out[rss_pkg::SPARE_MSB];
  assign host_port_select_strap_oe = pin_oe[rss_pkg::STRAP_HOST_SEL];
  assign spi_mode_strap_oe = pin_oe[rss_pkg::STRAP_SPI_MODE];
  assign integrity_method_strap_oe = pin_oe[rss_pkg::STRAP_INTEGRITY];
  assign boot_hold_strap_oe = pin_oe[rss_pkg::STRAP_BOOT_HOLD];
  assign spare_test_pin_a_oe = pin_oe[rss_pkg::SPARE_LSB];
  assign spare_test_pin_b_oe = pin_oe[rss_pkg::SPARE_LSB+1];
  assign spare_test_pin_c_oe = pin_oe[rss_pkg::SPARE_LSB+2];
  assign spare_test_pin_d_oe = pin_oe[rss_pkg::SPARE_MSB];

  // sequencer: count out the sample delay, capture once, then hold
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_valid = strap_valid;
    next_cmd_i2c = cmd_port_is_i2c;
    next_diag_i2c = diag_port_is_i2c;
    next_spi_mode = host_spi_mode_1_or_2;
    next_cmd_checksum = cmd_integrity_checksum;
    next_stay_boot = stay_in_boot;
    next_load_main = load_main_app;
    next_spare_fault = spare_pin_fault;
    unique case (state)
      rss_pkg::st_wait: begin
        // counting starts at the first edge after reset rises
        next_cnt = CNT_W'(cnt + rss_pkg::CNT_ONE);
        if (cnt == CNT_W'(SAMPLE_CYCLES - 1)) begin
          next_state = rss_pkg::st_capture;
        end
      end
      rss_pkg::st_capture: begin
        // an open pin reads low here, so it selects the zero option
        next_cmd_i2c = (pin_s[rss_pkg::STRAP_HOST_SEL] ==
                        rss_pkg::HOST_PORT_I2C);
        next_diag_i2c = (pin_s[rss_pkg::STRAP_HOST_SEL] ==
                         rss_pkg::HOST_PORT_SPI);
        next_spi_mode = (pin_s[rss_pkg::STRAP_SPI_MODE] ==
                         rss_pkg::SPI_MODE_1_OR_2);
        next_cmd_checksum = (pin_s[rss_pkg::STRAP_INTEGRITY] ==
                             rss_pkg::INTEGRITY_CHECKSUM8);
        next_stay_boot = (pin_s[rss_pkg::STRAP_BOOT_HOLD] ==
                          rss_pkg::BOOT_STAY);
        next_load_main = (pin_s[rss_pkg::STRAP_BOOT_HOLD] ==
                          rss_pkg::BOOT_LOAD_MAIN);
        // flag a board that drives a spare pin high at sampling
        next_spare_fault =
          |pin_s[rss_pkg::SPARE_MSB:rss_pkg::SPARE_LSB];
        next_valid = 1'b1;
        next_state = rss_pkg::st_run;
      end
      rss_pkg::st_run: begin
        // nothing reloads: only reset returns to the wait state
        next_state = rss_pkg::st_run;
      end
      default: begin
        next_state = rss_pkg::st_wait;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= rss_pkg::st_wait;
      cnt <= CNT_W'(rss_pkg::CNT_ZERO);
      strap_valid <= 1'b0;
      cmd_port_is_i2c <= 1'b0;
      diag_port_is_i2c <= 1'b0;
      host_spi_mode_1_or_2 <= 1'b0;
      cmd_integrity_checksum <= 1'b0;
      stay_in_boot <= 1'b0;
      load_main_app <= 1'b0;
      spare_pin_fault <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      strap_valid <= next_valid;
      cmd_port_is_i2c <= next_cmd_i2c;
      diag_port_is_i2c <= next_diag_i2c;
      host_spi_mode_1_or_2 <= next_spi_mode;
      cmd_integrity_checksum <= next_cmd_checksum;
      stay_in_boot <= next_stay_boot;
      load_main_app <= next_load_main;
      spare_pin_fault <= next_spare_fault;
    end
  end

  // diagnostic port integrity follows the stored flash setting, not a pin
  always_comb begin
    next_diag_checksum = flash_diag_checksum;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      diag_integrity_checksum <= 1'b0;
    end else if (ce) begin
      diag_integrity_checksum <= next_diag_checksum;
    end
  end

  // debug drive is gated by the registered valid, so a pin can never
  // turn around in the same cycle its level is being captured
  always_comb begin
    next_pin_oe = rss_pkg::PIN_IDLE;
    next_pin_out = rss_pkg::PIN_IDLE;
    if (strap_valid) begin
      next_pin_oe = debug_out_enable;
      next_pin_out = debug_out_enable & debug_out_value;
    end
  end

  // reset clears the enables at once: pins float while reset is low
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_oe <= rss_pkg::PIN_IDLE;
      pin_out <= rss_pkg::PIN_IDLE;
    end else if (ce) begin
      pin_oe <= next_pin_oe;
      pin_out <= next_pin_out;
    end
  end

  // enabled edges since reset release, read only by the checks below
  always_comb begin
    next_edges = edges;
    if (ce && edges != rss_pkg::EDGE_MAX) begin
      next_edges = 16'(edges + rss_pkg::EDGE_ONE);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      edges <= rss_pkg::EDGE_ZERO;
    end else begin
      edges <= next_edges;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // last enabled cycle of the delay count
  sequence s_last_wait;
    state == rss_pkg::st_wait && cnt == CNT_W'(SAMPLE_CYCLES - 1) && ce;
  endsequence

  // the enabled capture cycle
  sequence s_capture;
    state == rss_pkg::st_capture && ce;
  endsequence

  // capture followed by the valid flag
  sequence s_capture_done;
    s_capture ##1 strap_valid;
  endsequence

  property p_delay_then_capture;
    s_last_wait |=> state == rss_pkg::st_capture;
  endproperty

  property p_capture_sets_valid;
    s_capture |-> s_capture_done;
  endproperty

  sample_step_a: assert property (p_delay_then_capture)
    else $error("delay count did not lead to capture");

  capture_valid_a: assert property (p_capture_sets_valid)
    else $error("capture did not raise strap_valid");

  sample_time_a: assert property (
    $rose(strap_valid) |-> edges == 16'(SAMPLE_CYCLES + 1))
    else $error("straps sampled at the wrong time after reset");

  pins_float_a: assert property (
    !strap_valid |-> pin_oe == rss_pkg::PIN_IDLE)
    else $error("strap pin driven before sampling");

  debug_late_a: assert property (
    $rose(|pin_oe) |-> $past(strap_valid))
    else $error("debug drive started without sampled straps");

  host_port_a: assert property (
    s_capture |=> cmd_port_is_i2c ==
      $past(pin_s[rss_pkg::STRAP_HOST_SEL]))
    else $error("command port does not follow host select strap");

  diag_port_a: assert property (
    strap_valid |-> diag_port_is_i2c != cmd_port_is_i2c)
    else $error("diagnostic port equals command port");

  spi_mode_a: assert property (
    s_capture |=> host_spi_mode_1_or_2 ==
      $past(pin_s[rss_pkg::STRAP_SPI_MODE]))
    else $error("spi mode does not follow its strap");

  integrity_a: assert property (
    s_capture |=> cmd_integrity_checksum ==
      $past(pin_s[rss_pkg::STRAP_INTEGRITY]))
    else $error("command integrity does not follow its strap");

  diag_integ_a: assert property (
    ce |=> diag_integrity_checksum == $past(flash_diag_checksum))
    else $error("diagnostic integrity not from flash setting");

  boot_choice_a: assert property (
    s_capture |=> stay_in_boot == $past(pin_s[rss_pkg::STRAP_BOOT_HOLD])
      && load_main_app == !stay_in_boot)
    else $error("boot choice does not follow boot hold strap");

  straps_held_a: assert property (
    strap_valid |=> strap_valid && $stable(cmd_port_is_i2c) &&
      $stable(host_spi_mode_1_or_2) && $stable(cmd_integrity_checksum) &&
      $stable(stay_in_boot))
    else $error("latched strap value changed after sampling");

endmodule

// ===== verification/rss_board_model.sv
// board strap resistors and host drive as seen at the strap pins
`timescale 1ns/1ps
module rss_board_model (
  input wire logic [7:0] dev_oe,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] board_drive,
  input wire logic [7:0] board_level,
  input wire logic spare_break,
  output logic [7:0] pin_level
);
  logic [7:0] board_mask;
  // spare pins stay open unless a test breaks the board rule on purpose
  always_comb begin
    board_mask = board_drive;
    if (!spare_break) begin
      board_mask[7:4] = 4'h0;
    end
  end
  // device drive wins; an open pin reads 0, never the last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (dev_oe[i]) begin
        pin_level[i] = dev_out[i];
      end else if (board_mask[i]) begin
        pin_level[i] = board_level[i];
      end else begin
        pin_level[i] = 1'h0;
      end
    end
  end
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the reset strap sampler
`timescale 1ns/1ps
module tb_top;
  localparam int S = 4;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic ce = 1'h1;
  logic flash_diag_checksum = 1'h0;
  logic spare_break = 1'h0;
  logic [7:0] debug_out_enable = 8'h00;
  logic [7:0] debug_out_value = 8'h00;
  logic [7:0] board_drive = 8'h00;
  logic [7:0] board_level = 8'h00;
  logic [7:0] pin_v;
  // each bit is driven by its own port of the block, so these are nets
  wire [7:0] oe_v;
  wire [7:0] out_v;
  logic strap_valid, cmd_port_is_i2c, diag_port_is_i2c;
  logic host_spi_mode_1_or_2, cmd_integrity_checksum;
  logic diag_integrity_checksum, stay_in_boot, load_main_app;
  logic spare_pin_fault;
  int failures = 0;
  int check_count = 0;

  // free-running 25 MHz clock
  always begin
    #20 clk = ~clk;
  end

  rss_board_model board_u (.dev_oe(oe_v), .dev_out(out_v),
    .board_drive(board_drive), .board_level(board_level),
    .spare_break(spare_break), .pin_level(pin_v));

  rss_strap_sampler #(.SAMPLE_CYCLES(S), .CNT_W(6)) dut_u (
    .clk(clk), .rstn(rstn), .ce(ce),
    .host_port_select_strap_in(pin_v[0]),
    .host_port_select_strap_out(out_v[0]),
    .host_port_select_strap_oe(oe_v[0]),
    .spi_mode_strap_in(pin_v[1]), .spi_mode_strap_out(out_v[1]),
    .spi_mode_strap_oe(oe_v[1]),
    .integrity_method_strap_in(pin_v[2]),
    .integrity_method_strap_out(out_v[2]),
    .integrity_method_strap_oe(oe_v[2]),
    .boot_hold_strap_in(pin_v[3]), .boot_hold_strap_out(out_v[3]),
    .boot_hold_strap_oe(oe_v[3]),
    .spare_test_pin_a_in(pin_v[4]), .spare_test_pin_a_out(out_v[4]),
    .spare_test_pin_a_oe(oe_v[4]),
    .spare_test_pin_b_in(pin_v[5]), .spare_test_pin_b_out(out_v[5]),
    .spare_test_pin_b_oe(oe_v[5]),
    .spare_test_pin_c_in(pin_v[6]), .spare_test_pin_c_out(out_v[6]),
    .spare_test_pin_c_oe(oe_v[6]),
    .spare_test_pin_d_in(pin_v[7]), .spare_test_pin_d_out(out_v[7]),
    .spare_test_pin_d_oe(oe_v[7]),
    .flash_diag_checksum(flash_diag_checksum),
    .debug_out_enable(debug_out_enable),
    .debug_out_value(debug_out_value), .strap_valid(strap_valid),
    .cmd_port_is_i2c(cmd_port_is_i2c), .diag_port_is_i2c(diag_port_is_i2c),
    .host_spi_mode_1_or_2(host_spi_mode_1_or_2),
    .cmd_integrity_checksum(cmd_integrity_checksum),
    .diag_integrity_checksum(diag_integrity_checksum),
    .stay_in_boot(stay_in_boot), .load_main_app(load_main_app),
    .spare_pin_fault(spare_pin_fault));

  task automatic check_bit(input logic got, input logic exp,
                           input string msg);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask

  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp,
                           input string msg);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // decoded outputs against the captured strap levels s
  task automatic check_decode(input logic [7:0] s);
    check_bit(strap_valid, 1'h1, "valid");
    check_bit(cmd_port_is_i2c, s[0], "cmd port");
    check_bit(diag_port_is_i2c, ~s[0], "diag port");
    check_bit(host_spi_mode_1_or_2, s[1], "spi mode");
    check_bit(cmd_integrity_checksum, s[2], "cmd integrity");
    check_bit(stay_in_boot, s[3], "stay");
    check_bit(load_main_app, ~s[3], "load main");
    check_bit(spare_pin_fault, |s[7:4], "spare fault");
  endtask

  // one power-on cycle; stall holds ce low right after release
  task automatic boot(input logic [7:0] lvl, input logic [7:0] drv,
                      input logic brk, input int stall);
    logic [7:0] s;
    s = lvl & drv & (brk ? 8'hff : 8'h0f);
    @(posedge clk);
    rstn <= 1'h0;
    board_drive <= drv;
    board_level <= lvl;
    spare_break <= brk;
    debug_out_enable <= 8'hff;
    debug_out_value <= ~s;
    repeat (4) @(posedge clk);
    #1 check_vec(oe_v, 8'h00, "pins floating in reset");
    @(posedge clk);
    rstn <= 1'h1;
    if (stall > 0) begin
      ce <= 1'h0;
      repeat (stall) @(posedge clk);
      ce <= 1'h1;
    end
    repeat (S) @(posedge clk);
    #1 check_bit(strap_valid, 1'h0, "valid early");
    check_vec(oe_v, 8'h00, "drive before capture");
    @(posedge clk);
    #1 check_decode(s);
    check_vec(oe_v, 8'h00, "drive at capture");
    @(posedge clk);
    board_level <= ~lvl;
    debug_out_enable <= 8'h00;
    #1 check_vec(oe_v, 8'hff, "debug enable");
    check_vec(out_v, ~s, "debug value");
    repeat (3) @(posedge clk);
    #1 check_vec(oe_v, 8'h00, "debug release");
    check_decode(s);
    $display("test boot %h %h done", lvl, drv);
  endtask

  // each debug bit drives only its own pin, one edge later; value is all
  // ones so a pin that is not enabled must still read its value as 0
  task automatic debug_walk();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      debug_out_enable <= 8'h01 << i;
      debug_out_value <= 8'hff;
      @(posedge clk);
      #1 check_vec(oe_v, 8'h01 << i, "walk enable");
      check_vec(out_v, 8'h01 << i, "walk value");
    end
    // reset while a pin is driven: the drive must drop at once
    @(posedge clk);
    rstn <= 1'h0;
    debug_out_enable <= 8'h00;
    #1 check_vec(oe_v, 8'h00, "drive cut by reset");
    check_bit(strap_valid, 1'h0, "valid cleared by reset");
    $display("test debug walk done");
  endtask

  // diagnostic integrity follows flash, not the strap
  task automatic flash_test(input logic strap_val);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      flash_diag_checksum <= ~i[0];
      @(posedge clk);
      #1 check_bit(diag_integrity_checksum, ~i[0], "diag flash");
      check_bit(cmd_integrity_checksum, strap_val, "cmd strap");
    end
    $display("test flash setting done");
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // whole run is about 120 cycles; cut a hang well beyond that
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    boot(8'hff, 8'h00, 1'h0, 0);
    boot(8'hff, 8'hff, 1'h0, 0);
    boot(8'h05, 8'hff, 1'h0, 3);
    boot(8'h0a, 8'hff, 1'h0, 0);
    boot(8'h90, 8'hff, 1'h1, 0);
    boot(8'h04, 8'h0f, 1'h0, 0);
    flash_test(1'h1);
    debug_walk();
    print_verdict();
  end
endmodule
